/* src/bst_consts.svh */
`ifndef BST_CONSTS_SVH
`define BST_CONSTS_SVH

// instruction register width and opcodes
`define BST_IR_W 6
`define BST_OP_EXTEST 6'h00
`define BST_OP_SAMPLE 6'h01
`define BST_OP_IDSEL 6'h02
`define BST_OP_HIGHZ 6'h03
`define BST_OP_CLAMP 6'h3E
`define BST_OP_BYPASS 6'h3F

// value loaded into the instruction shift stage at capture
`define BST_IR_CAPTURE 6'h2D

// instruction current after test-logic reset
`define BST_IR_RESET `BST_OP_IDSEL

// identification register
`define BST_ID_W 32

// consecutive tms-high edges that always reach test-logic reset
`define BST_TLR_EDGES 3'h5

`endif

/* src/bst_pkg.sv */
package bst_pkg;

  typedef enum logic [15:0] {
    ST_TLR = 16'h0001,
    ST_RTI = 16'h0002,
    ST_SELDR = 16'h0004,
    ST_CAPDR = 16'h0008,
    ST_SDR = 16'h0010,
    ST_EX1DR = 16'h0020,
    ST_PDR = 16'h0040,
    ST_EX2DR = 16'h0080,
    ST_UPDDR = 16'h0100,
    ST_SELIR = 16'h0200,
    ST_CAPIR = 16'h0400,
    ST_SIR = 16'h0800,
    ST_EX1IR = 16'h1000,
    ST_PIR = 16'h2000,
    ST_EX2IR = 16'h4000,
    ST_UPDIR = 16'h8000
  } bst_state_e;

  // raw test pins as they arrive from the tester
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } bst_pins_s;

endpackage

/* src/bst_tap.sv */
`timescale 1ns/1ps
`include "bst_consts.svh"
// Operation
// - sixteen-state tap machine and six-bit instruction register on five test pins.
// - low trst forces test-logic reset at once, independent of tck; pulled high.
// - tms and tdi are sampled on each rising tck edge.
// - tdo changes only on falling tck edges.
// - tdo is driven only in shift-dr or shift-ir, otherwise high impedance.
// - one state step per rising tck edge chosen by tms; tester supplies tms.
// - five consecutive tms-high rising edges reach test-logic reset from anywhere.
// - bypass, boundary and identification registers sit in parallel, chosen by instruction.
// - boundary chain is the data path under external test or sample/preload.
// - external test at update-ir drives pins from boundary update latches at once.
// - every boundary cell holds its update value in a falling-edge latch.
// - input-pin cells only observe and capture; they never drive the core.
// - each bidirectional pin has one enable cell and one muxed capture cell.
// - outside external test with enable high, capture core output data.
// - with enable low or under external test, capture pad input data.
// - only dc-coupled pins are scanned; no ac test mode exists.
// - opcodes 000000 external test, 000001 sample/preload, 111111 bypass.
// - capture-ir loads 101101 into the instruction shift stage.
// - a shifted instruction takes effect only at update-ir.
// - bypass bit captures zero at every capture-dr while neither boundary nor identification register is selected.
module bst_tap
  import bst_pkg::*;
#(
  parameter int N_IN = 4,
  parameter int N_OUT = 4,
  parameter int N_BD = 2,
  parameter logic [31:0] ID_VALUE = 32'h0000_0001 // arbitrary, lsb must be one
) (
  // system
  input wire logic clk,
  input wire logic sys_rst,
  // test pins
  input wire bst_pins_s pins,
  output logic tdo_o,
  output logic tdo_oe_n,
  // input pins, observed only
  input wire logic [N_IN-1:0] pad_in,
  // output pins
  input wire logic [N_OUT-1:0] core_out,
  output logic [N_OUT-1:0] pad_out,
  // bidirectional pins
  input wire logic [N_BD-1:0] core_bd_out,
  input wire logic [N_BD-1:0] core_bd_oe,
  input wire logic [N_BD-1:0] pad_bd_in,
  output logic [N_BD-1:0] pad_bd_out,
  output logic [N_BD-1:0] pad_bd_oe_n
);

  localparam int BSR_W = N_IN + N_OUT + 2 * N_BD;

  // trst acts without any clock edge; sys_rst covers power-up
  logic tap_rst;
  assign tap_rst = sys_rst | ~pins.trst_n;

  // tck is just another outside level here; three stages give synced level and edge
  logic [2:0] tck_q;
  logic [1:0] tms_q;
  logic [1:0] tdi_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tck_q <= 3'h0;
      tms_q <= 2'h3;
      tdi_q <= 2'h3;
    end else begin
      tck_q <= {tck_q[1:0], pins.tck};
      tms_q <= {tms_q[0], pins.tms};
      tdi_q <= {tdi_q[0], pins.tdi};
    end
  end

  logic tck_rise;
  logic tck_fall;
  logic tms_s;
  logic tdi_s;
  assign tck_rise = tck_q[1] & ~tck_q[2];
  assign tck_fall = ~tck_q[1] & tck_q[2];
  assign tms_s = tms_q[1];
  assign tdi_s = tdi_q[1];

  bst_state_e st_q;
  bst_state_e st_d;

  always_comb begin
    unique case (st_q)
      ST_TLR: st_d = tms_s ? ST_TLR : ST_RTI;
      ST_RTI: st_d = tms_s ? ST_SELDR : ST_RTI;
      ST_SELDR: st_d = tms_s ? ST_SELIR : ST_CAPDR;
      ST_CAPDR: st_d = tms_s ? ST_EX1DR : ST_SDR;
      ST_SDR: st_d = tms_s ? ST_EX1DR : ST_SDR;
      ST_EX1DR: st_d = tms_s ? ST_UPDDR : ST_PDR;
      ST_PDR: st_d = tms_s ? ST_EX2DR : ST_PDR;
      ST_EX2DR: st_d = tms_s ? ST_UPDDR : ST_SDR;
      ST_UPDDR: st_d = tms_s ? ST_SELDR : ST_RTI;
      ST_SELIR: st_d = tms_s ? ST_TLR : ST_CAPIR;
      ST_CAPIR: st_d = tms_s ? ST_EX1IR : ST_SIR;
      ST_SIR: st_d = tms_s ? ST_EX1IR : ST_SIR;
      ST_EX1IR: st_d = tms_s ? ST_UPDIR : ST_PIR;
      ST_PIR: st_d = tms_s ? ST_EX2IR : ST_PIR;
      ST_EX2IR: st_d = tms_s ? ST_UPDIR : ST_SIR;
      ST_UPDIR: st_d = tms_s ? ST_SELDR : ST_RTI;
      default: st_d = ST_TLR;
    endcase
  end

  always_ff @(posedge clk or posedge tap_rst) begin
    if (tap_rst) begin
      st_q <= ST_TLR;
    end else if (tck_rise) begin
      st_q <= st_d;
    end
  end

  // instruction register: shift stage on rise, current stage on fall
  logic [`BST_IR_W-1:0] ir_sr_q;
  logic [`BST_IR_W-1:0] ir_q;

  always_ff @(posedge clk or posedge tap_rst) begin
    if (tap_rst) begin
      ir_sr_q <= `BST_IR_CAPTURE;
    end else if (tck_rise && st_q == ST_CAPIR) begin
      ir_sr_q <= `BST_IR_CAPTURE;
    end else if (tck_rise && st_q == ST_SIR) begin
      ir_sr_q <= {tdi_s, ir_sr_q[`BST_IR_W-1:1]};
    end
  end

  always_ff @(posedge clk or posedge tap_rst) begin
    if (tap_rst) begin
      ir_q <= `BST_IR_RESET;
    end else if (tck_fall && st_q == ST_TLR) begin
      ir_q <= `BST_IR_RESET;
    end else if (tck_fall && st_q == ST_UPDIR) begin
      ir_q <= ir_sr_q;
    end
  end

  // decode; highz, clamp and reserved codes fall through to bypass
  logic is_extest;
  logic is_clamp;
  logic is_highz;
  logic sel_bsr;
  logic sel_id;
  assign is_extest = ir_q == `BST_OP_EXTEST;
  assign is_clamp = ir_q == `BST_OP_CLAMP;
  assign is_highz = ir_q == `BST_OP_HIGHZ;
  assign sel_bsr = is_extest || ir_q == `BST_OP_SAMPLE;
  assign sel_id = ir_q == `BST_OP_IDSEL;

  // boundary chain layout, lsb nearest tdo: inputs, outputs, enables, bidir data
  logic [BSR_W-1:0] bsr_q;
  logic [BSR_W-1:0] upd_q;
  logic [BSR_W-1:0] bsr_cap;
  logic [N_BD-1:0] bd_cap;

  // enable cell high and no external test: watch the core driving the pad
  genvar g;
  generate
    for (g = 0; g < N_BD; g++) begin : g_bd
      assign bd_cap[g] = (~is_extest & core_bd_oe[g]) ?
        core_bd_out[g] : pad_bd_in[g];
    end
  endgenerate

  // only dc pins exist on this chain; no ac stimulus is generated
  assign bsr_cap = {bd_cap, core_bd_oe, core_out, pad_in};

  logic run_dr_cap;
  logic run_dr_sh;
  assign run_dr_cap = tck_rise && st_q == ST_CAPDR;
  assign run_dr_sh = tck_rise && st_q == ST_SDR;

  always_ff @(posedge clk or posedge tap_rst) begin
    if (tap_rst) begin
      bsr_q <= '0;
    end else if (sel_bsr && run_dr_cap) begin
      bsr_q <= bsr_cap;
    end else if (sel_bsr && run_dr_sh) begin
      bsr_q <= {tdi_s, bsr_q[BSR_W-1:1]};
    end
  end

  // update stage follows the falling edge so skew on the shift stage cannot leak out
  always_ff @(posedge clk or posedge tap_rst) begin
    if (tap_rst) begin
      upd_q <= '0;
    end else if (tck_fall && st_q == ST_UPDDR && sel_bsr) begin
      upd_q <= bsr_q;
    end
  end

  logic byp_q;
  always_ff @(posedge clk or posedge tap_rst) begin
    if (tap_rst) begin
      byp_q <= 1'h0;
    end else if (!sel_bsr && !sel_id && run_dr_cap) begin
      byp_q <= 1'h0;
    end else if (!sel_bsr && !sel_id && run_dr_sh) begin
      byp_q <= tdi_s;
    end
  end

  logic [`BST_ID_W-1:0] id_q;
  always_ff @(posedge clk or posedge tap_rst) begin
    if (tap_rst) begin
      id_q <= '0;
    end else if (sel_id && run_dr_cap) begin
      id_q <= ID_VALUE;
    end else if (sel_id && run_dr_sh) begin
      id_q <= {tdi_s, id_q[`BST_ID_W-1:1]};
    end
  end

  logic tdo_src;
  always_comb begin
    if (st_q == ST_SIR) begin
      tdo_src = ir_sr_q[0];
    end else if (sel_bsr) begin
      tdo_src = bsr_q[0];
    end else if (sel_id) begin
      tdo_src = id_q[0];
    end else begin
      tdo_src = byp_q;
    end
  end

  logic in_shift;
  assign in_shift = st_q == ST_SDR || st_q == ST_SIR;

  always_ff @(posedge clk or posedge tap_rst) begin
    if (tap_rst) begin
      tdo_o <= 1'h0;
      tdo_oe_n <= 1'h1;
    end else if (tck_fall) begin
      tdo_o <= tdo_src;
      tdo_oe_n <= ~in_shift;
    end
  end

  // pins: update latches take over as soon as the instruction register says so
  logic hold_pins;
  logic [N_OUT-1:0] upd_out;
  logic [N_BD-1:0] upd_oe;
  logic [N_BD-1:0] upd_bd;
  assign hold_pins = is_extest | is_clamp;
  assign upd_out = upd_q[N_IN +: N_OUT];
  assign upd_oe = upd_q[N_IN+N_OUT +: N_BD];
  assign upd_bd = upd_q[N_IN+N_OUT+N_BD +: N_BD];
  assign pad_out = hold_pins ? upd_out : core_out;
  assign pad_bd_out = hold_pins ? upd_bd : core_bd_out;
  assign pad_bd_oe_n = is_highz ? {N_BD{1'h1}} : ~(hold_pins ? upd_oe : core_bd_oe);

  // helper: consecutive tms-high rising edges
  logic [2:0] tms_run_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tms_run_q <= 3'h0;
    end else if (tck_rise) begin
      tms_run_q <= !tms_s ? 3'h0 : (tms_run_q == `BST_TLR_EDGES) ? tms_run_q : tms_run_q + 3'h1;
    end
  end

  a_five_tms_reset: assert property (@(posedge clk) disable iff (tap_rst)
    tms_run_q == `BST_TLR_EDGES |-> st_q == ST_TLR)
    else $error("five tms-high edges did not reach test-logic reset");

  a_trst_forces: assert property (@(posedge clk) disable iff (sys_rst)
    !pins.trst_n |=> st_q == ST_TLR && ir_q == `BST_IR_RESET)
    else $error("trst did not force reset state");

  a_tdo_fall_only: assert property (@(posedge clk) disable iff (tap_rst)
    $changed(tdo_o) || $changed(tdo_oe_n) |-> $past(tck_fall))
    else $error("tdo changed away from a falling tck edge");

  a_tdo_drive_shift: assert property (@(posedge clk) disable iff (tap_rst)
    $fell(tdo_oe_n) |-> $past(st_q == ST_SDR || st_q == ST_SIR))
    else $error("tdo driven outside a shift state");

  a_tdo_idle_release: assert property (@(posedge clk) disable iff (tap_rst)
    tck_fall && !in_shift |=> tdo_oe_n == 1'h1)
    else $error("tdo still driven outside a shift state");

  a_rti_to_seldr: assert property (@(posedge clk) disable iff (tap_rst)
    tck_rise && st_q == ST_RTI && tms_s |=> st_q == ST_SELDR)
    else $error("wrong step out of run-test-idle");

  a_selir_to_tlr: assert property (@(posedge clk) disable iff (tap_rst)
    tck_rise && st_q == ST_SELIR && tms_s |=> st_q == ST_TLR)
    else $error("wrong step out of select-ir");

  a_ir_capture_value: assert property (@(posedge clk) disable iff (tap_rst)
    tck_rise && st_q == ST_CAPIR |=> ir_sr_q == `BST_IR_CAPTURE)
    else $error("capture-ir did not load the fixed pattern");

  a_ir_update_only: assert property (@(posedge clk) disable iff (tap_rst)
    $changed(ir_q) |-> $past(tck_fall) && $past(st_q == ST_UPDIR || st_q == ST_TLR))
    else $error("instruction changed outside update-ir");

  a_bypass_zero: assert property (@(posedge clk) disable iff (tap_rst)
    run_dr_cap && !sel_bsr && !sel_id |=> byp_q == 1'h0)
    else $error("bypass bit did not capture zero");

  a_bypass_to_tdo: assert property (@(posedge clk) disable iff (tap_rst)
    tck_fall && st_q == ST_SDR && !sel_bsr && !sel_id |=> tdo_o == $past(byp_q))
    else $error("bypass bit not on tdo");

  a_bidir_capture: assert property (@(posedge clk) disable iff (tap_rst)
    run_dr_cap && sel_bsr |=> bsr_q[N_IN+N_OUT+N_BD +: N_BD] ==
      $past((~{N_BD{is_extest}} & core_bd_oe & core_bd_out) |
            (({N_BD{is_extest}} | ~core_bd_oe) & pad_bd_in)))
    else $error("bidirectional cell captured the wrong side");

  a_extest_pins: assert property (@(posedge clk) disable iff (tap_rst)
    is_extest |-> pad_out == upd_q[N_IN +: N_OUT] && pad_bd_oe_n == ~upd_q[N_IN+N_OUT +: N_BD])
    else $error("external test pins not driven from update latches");

  a_update_fall_only: assert property (@(posedge clk) disable iff (tap_rst)
    $changed(upd_q) |-> $past(tck_fall) && $past(st_q == ST_UPDDR))
    else $error("boundary update latch moved outside update-dr");

  a_reset_idsel: assert property (@(posedge clk) disable iff (tap_rst)
    tck_fall && st_q == ST_TLR |=> ir_q == `BST_OP_IDSEL)
    else $error("reset did not restore identification instruction");

  a_bsr_to_tdo: assert property (@(posedge clk) disable iff (tap_rst)
    tck_fall && st_q == ST_SDR && sel_bsr |=> tdo_o == $past(bsr_q[0]))
    else $error("boundary chain not on tdo");

  c_extest_active: cover property (@(posedge clk) disable iff (tap_rst)
    $rose(is_extest));
  c_id_shift: cover property (@(posedge clk) disable iff (tap_rst)
    sel_id && tck_fall && st_q == ST_SDR);
  c_tms_reset: cover property (@(posedge clk) disable iff (tap_rst)
    tms_run_q == `BST_TLR_EDGES && $past(st_q != ST_TLR));
  c_bidir_core: cover property (@(posedge clk) disable iff (tap_rst)
    run_dr_cap && sel_bsr && !is_extest && core_bd_oe[0]);
  c_clamp_active: cover property (@(posedge clk) disable iff (tap_rst)
    $rose(is_clamp));

endmodule

/* bench/bst_tester.sv */
`timescale 1ns/1ps
module bst_tester
  import bst_pkg::*;
(
  // system
  input wire logic clk,
  // serial return from the tap
  input wire logic tdo_o,
  input wire logic tdo_oe_n,
  // test pins
  output bst_pins_s pins
);
  logic last_q = 1'b0;
  logic tdo_seen;

  // a released tdo shows the inverse of its last level, so a stale bit never passes
  always @(posedge clk) begin
    if (!tdo_oe_n) begin
      last_q <= tdo_o;
    end
  end
  assign tdo_seen = tdo_oe_n ? ~last_q : tdo_o;

  // tck rests low between steps; trst idles high as its pull-up would hold it
  initial begin
    pins = '{tck: 1'b0, tms: 1'b1, tdi: 1'b0, trst_n: 1'b1};
  end

  // one tck period of 8 clk; tdo is read late in the high phase, before the fall moves it
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    @(posedge clk);
    pins.tms <= tms;
    pins.tdi <= tdi;
    repeat (3) @(posedge clk);
    pins.tck <= 1'b1;
    repeat (3) @(posedge clk);
    #1 tdo = tdo_seen;
    @(posedge clk);
    pins.tck <= 1'b0;
  endtask

  // tck stands still while reset is pulled
  task automatic pulse_reset();
    @(posedge clk);
    pins.trst_n <= 1'b0;
    repeat (2) @(posedge clk);
    pins.trst_n <= 1'b1;
  endtask
endmodule

/* bench/tb_boundary_scan_tap.sv */
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin \
  comparisons++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("wrong value at %0t ns: %s", $time, msg); \
  end \
end

module tb_boundary_scan_tap;
  localparam logic [31:0] ID = 32'h0000_A5A5; // arbitrary, lsb one
  logic clk;
  logic sys_rst;
  bst_pkg::bst_pins_s pins;
  logic tdo_o;
  logic tdo_oe_n;
  logic [3:0] pad_in;
  logic [3:0] core_out;
  logic [3:0] pad_out;
  logic [1:0] core_bd_out;
  logic [1:0] core_bd_oe;
  logic [1:0] pad_bd_in;
  logic [1:0] pad_bd_out;
  logic [1:0] pad_bd_oe_n;
  logic [31:0] cap;
  int miscompares = 0;
  int comparisons = 0;

  bst_tap #(.N_IN(4), .N_OUT(4), .N_BD(2), .ID_VALUE(ID)) u_bst_tap (.clk(clk),
    .sys_rst(sys_rst), .pins(pins), .tdo_o(tdo_o), .tdo_oe_n(tdo_oe_n), .pad_in(pad_in),
    .core_out(core_out), .pad_out(pad_out), .core_bd_out(core_bd_out),
    .core_bd_oe(core_bd_oe), .pad_bd_in(pad_bd_in), .pad_bd_out(pad_bd_out),
    .pad_bd_oe_n(pad_bd_oe_n));
  bst_tester u_bst_tester (.clk(clk), .tdo_o(tdo_o), .tdo_oe_n(tdo_oe_n), .pins(pins));

  task automatic tick(input logic tms);
    logic b;
    u_bst_tester.step(tms, 1'b0, b);
  endtask

  task automatic shift(input int n, input logic [31:0] din, output logic [31:0] dout);
    logic b;
    dout = '0;
    for (int i = 0; i < n; i++) begin
      u_bst_tester.step(i == n - 1, din[i], b);
      dout[i] = b;
      if (i == 0) `CHK(tdo_oe_n, 1'b0, "tdo released in shift")
    end
    tick(1'b1);
    tick(1'b0);
    `CHK(tdo_oe_n, 1'b1, "tdo driven outside shift")
  endtask

  task automatic ir_scan(input logic [5:0] op);
    logic [31:0] c;
    tick(1'b1);
    tick(1'b1);
    tick(1'b0);
    tick(1'b0);
    shift(6, {26'h0, op}, c);
    `CHK(c[5:0], 6'h2D, "ir capture pattern")
  endtask

  task automatic dr_scan(input int n, input logic [31:0] din);
    tick(1'b1);
    tick(1'b0);
    tick(1'b0);
    shift(n, din, cap);
  endtask

  task automatic core_pads();
    `CHK(pad_out, core_out, "pad_out not core")
    `CHK(pad_bd_out, core_bd_out, "bidir data not core")
    `CHK(pad_bd_oe_n, ~core_bd_oe, "bidir enable not core")
  endtask

  task automatic t_reset_state();
    core_pads();
    `CHK(tdo_oe_n, 1'b1, "tdo driven after reset")
    tick(1'b0);
    dr_scan(32, 32'h0);
    `CHK(cap, ID, "identification after reset")
    $display("test reset_state done");
  endtask

  task automatic t_sample();
    @(posedge clk);
    pad_in <= 4'h9;
    core_out <= 4'h6;
    core_bd_oe <= 2'b01;
    core_bd_out <= 2'b11;
    pad_bd_in <= 2'b00;
    ir_scan(6'h01);
    dr_scan(12, 32'h93F);
    `CHK(cap[11:0], 12'h569, "sample capture")
    core_pads();
    $display("test sample_preload done");
  endtask

  // preload came first, so extest puts known values on the pins
  task automatic t_extest();
    ir_scan(6'h00);
    `CHK(pad_out, 4'h3, "extest pad_out")
    `CHK(pad_bd_out, 2'b10, "extest bidir data")
    `CHK(pad_bd_oe_n, 2'b10, "extest bidir enable")
    @(posedge clk);
    pad_bd_in <= 2'b10;
    core_bd_oe <= 2'b11;
    core_bd_out <= 2'b01;
    dr_scan(12, 32'h6C0);
    `CHK(cap[11:0], 12'hB69, "extest capture")
    `CHK(pad_out, 4'hC, "update pad_out")
    `CHK(pad_bd_oe_n, 2'b01, "update bidir enable")
    `CHK(pad_bd_out, 2'b01, "update bidir data")
    $display("test extest done");
  endtask

  task automatic t_trst();
    u_bst_tester.pulse_reset();
    repeat (2) @(posedge clk);
    `CHK(pad_out, core_out, "trst left extest")
    core_pads();
    tick(1'b0);
    $display("test trst done");
  endtask

  task automatic t_tms_reset();
    @(posedge clk);
    core_out <= 4'hF;
    ir_scan(6'h00);
    `CHK(pad_out, 4'h0, "extest with cleared latches")
    tick(1'b1);
    tick(1'b0);
    tick(1'b0);
    repeat (5) tick(1'b1);
    tick(1'b0);
    `CHK(pad_out, core_out, "five tms highs")
    dr_scan(32, 32'h0);
    `CHK(cap, ID, "identification after tms reset")
    $display("test tms_reset done");
  endtask

  task automatic t_bypass();
    logic [5:0] ops [3] = '{6'h3F, 6'h04, 6'h2E};
    foreach (ops[k]) begin
      ir_scan(ops[k]);
      core_pads();
      dr_scan(8, 32'hB6);
      `CHK(cap[7:0], 8'h6C, "one-bit bypass path")
    end
    $display("test bypass done");
  endtask

  // clamp holds preloaded pins while only the bypass bit shifts; highz floats the bidirs
  task automatic t_clamp_highz();
    ir_scan(6'h01);
    dr_scan(12, 32'hA5A);
    ir_scan(6'h3E);
    `CHK(pad_out, 4'h5, "clamp pad_out")
    `CHK(pad_bd_out, 2'b10, "clamp bidir data")
    `CHK(pad_bd_oe_n, 2'b01, "clamp bidir enable")
    dr_scan(8, 32'h4D);
    `CHK(cap[7:0], 8'h9A, "clamp bypass path")
    ir_scan(6'h03);
    `CHK(pad_bd_oe_n, 2'b11, "highz bidir enable")
    `CHK(pad_out, core_out, "highz pad_out")
    dr_scan(8, 32'h4D);
    `CHK(cap[7:0], 8'h9A, "highz bypass path")
    $display("test clamp_highz done");
  endtask

  task automatic give_verdict();
    $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    sys_rst = 1'b1;
    pad_in = 4'h0;
    core_out = 4'h5;
    core_bd_out = 2'b01;
    core_bd_oe = 2'b10;
    pad_bd_in = 2'b00;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_reset_state();
    t_sample();
    t_extest();
    t_trst();
    t_tms_reset();
    t_bypass();
    t_clamp_highz();
    give_verdict();
  end

  // the whole run needs about 2500 clk
  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    $display("wrong value at %0t ns: watchdog expired", $time);
    give_verdict();
  end
endmodule
